// ---- afe_ctrl_regs.sv ----
// Control register bank of the measurement front end behind the serial slave:
// thermal config, conversion trigger, port lock, enables, sample timing.
// The sensor raises sensor_done for one cycle per finished conversion.
`timescale 1ns/10ps
`default_nettype none
`include "afe_regs.svh"
module afe_ctrl_regs
	import afe_pkg::*;
#(
	parameter int SAMPLE_CYCLES = `AFE_SAMPLE_CYCLES,
	parameter int SAMPLES_PER_ACC = `AFE_SAMPLES_PER_ACC
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire logic sensor_done,
	output logic temp_start,
	output logic supply_start,
	output logic adc_enable,
	output logic ce_enable,
	output logic sample_tick,
	output logic accum_done,
	output logic fe_reset
);
	logic rd_stb, wr_stb, acc_ok, wr, wr_trig, rst_wr, auto_req;
	logic [11:0] addr;
	logic [31:0] wdata, rdata;
	logic [1:0] per_q, per_d, en_q, en_d;
	logic sup_q, sup_d, trig_q, trig_d, lock_q, lock_d, rflag_q, rflag_d;
	logic tstart_q, tstart_d, sstart_q, sstart_d, acc_q, acc_d, fer_q, fer_d, tick_q, tick_d;
	logic [31:0] div_q, div_d;
	logic [11:0] cnt_q, cnt_d;
	afe_meas_state_e st_q, st_d;

	afe_spi_slave u_spi (
		.clk(clk),
		.rstn(rstn),
		.spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe),
		.rd_stb(rd_stb),
		.wr_stb(wr_stb),
		.addr(addr),
		.wdata(wdata),
		.rdata(rdata)
	);

	assign acc_ok = ~lock_q | (addr == `AFE_OFS_LOCK); // R06
	assign wr = wr_stb & acc_ok; // R06
	assign wr_trig = wr & (addr == `AFE_OFS_TRIG) & (wdata == `AFE_TRIG_VALUE); // R03
	assign rst_wr = wr & (addr == `AFE_OFS_RESET) & (wdata == `AFE_RESET_VALUE); // R12
	assign auto_req = (per_q == `AFE_PER_CONT) | ((per_q == `AFE_PER_ACCUM) & acc_q); // R01

	// Read mux; locked or unmapped offsets answer zero
	always_comb
	begin
		rdata = 32'h0000_0000;
		if (acc_ok)
		begin
			case (addr)
				`AFE_OFS_STATUS:
				begin
					rdata[`AFE_STAT_RST_BIT] = rflag_q;
					rdata[`AFE_STAT_RST_COPY_BIT] = rflag_q;
				end
				`AFE_OFS_CFG:
				begin
					rdata[`AFE_CFG_PER_MSB:`AFE_CFG_PER_LSB] = per_q; // R13
					rdata[`AFE_CFG_SUP_BIT] = sup_q;
				end
				`AFE_OFS_TRIG: rdata[`AFE_TRIG_BIT] = trig_q; // R04
				`AFE_OFS_LOCK: rdata = lock_q ? `AFE_LOCK_VALUE : `AFE_UNLOCK_VALUE;
				`AFE_OFS_EN: rdata[1:0] = en_q;
				default: rdata = 32'h0000_0000;
			endcase
		end
	end

	always_comb
	begin
		per_d = per_q;
		sup_d = sup_q;
		trig_d = trig_q;
		lock_d = lock_q;
		en_d = en_q;
		rflag_d = rflag_q;
		st_d = st_q;
		div_d = div_q;
		cnt_d = cnt_q;
		tstart_d = 1'b0;
		sstart_d = 1'b0;
		acc_d = 1'b0;
		tick_d = 1'b0;
		fer_d = 1'b0;
		if (wr && addr == `AFE_OFS_CFG)
		begin
			per_d = wdata[`AFE_CFG_PER_MSB:`AFE_CFG_PER_LSB]; // R13
			sup_d = wdata[`AFE_CFG_SUP_BIT];
		end
		if (wr && addr == `AFE_OFS_EN)
			en_d = wdata[1:0]; // R13
		if (wr && addr == `AFE_OFS_LOCK && wdata == `AFE_LOCK_VALUE)
			lock_d = 1'b1; // R05
		if (wr && addr == `AFE_OFS_LOCK && wdata == `AFE_UNLOCK_VALUE)
			lock_d = 1'b0; // R07
		// Sample clock runs only while the converter is enabled
		if (en_q[`AFE_EN_ADC_BIT]) // R08
		begin
			if (div_q == 32'(SAMPLE_CYCLES - 1)) // R11
			begin
				div_d = 32'h0000_0000;
				tick_d = 1'b1;
			end
			else
				div_d = div_q + 32'h0000_0001;
		end
		else
			div_d = 32'h0000_0000;
		if (!en_q[`AFE_EN_CE_BIT]) // R09
			cnt_d = 12'h000;
		else if (tick_q)
		begin
			if (cnt_q == 12'(SAMPLES_PER_ACC - 1)) // R10
			begin
				cnt_d = 12'h000;
				acc_d = 1'b1;
			end
			else
				cnt_d = cnt_q + 12'h001;
		end
		case (st_q)
			AFE_ST_IDLE:
				if (trig_q || auto_req) // R03 R01
				begin
					st_d = AFE_ST_TEMP;
					tstart_d = 1'b1;
				end
			AFE_ST_TEMP:
				if (sensor_done)
				begin
					if (sup_q) // R02
					begin
						st_d = AFE_ST_SUPPLY;
						sstart_d = 1'b1;
					end
					else
					begin
						st_d = AFE_ST_IDLE;
						trig_d = 1'b0; // R04
					end
				end
			AFE_ST_SUPPLY:
				if (sensor_done)
				begin
					st_d = AFE_ST_IDLE;
					trig_d = 1'b0; // R04
				end
			default: st_d = AFE_ST_IDLE;
		endcase
		// New trigger beats the completion clear in the same cycle
		if (wr_trig)
			trig_d = 1'b1; // R03
		if (rst_wr) // R12
		begin
			per_d = 2'h0;
			sup_d = 1'b0;
			trig_d = 1'b0;
			lock_d = 1'b0;
			en_d = 2'h0;
			st_d = AFE_ST_IDLE;
			div_d = 32'h0000_0000;
			cnt_d = 12'h000;
			tstart_d = 1'b0;
			sstart_d = 1'b0;
			rflag_d = 1'b1;
			fer_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			per_q <= 2'h0;
			sup_q <= 1'b0;
			trig_q <= 1'b0;
			lock_q <= 1'b0;
			en_q <= 2'h0;
			rflag_q <= 1'b0;
			st_q <= AFE_ST_IDLE;
			div_q <= 32'h0000_0000;
			cnt_q <= 12'h000;
			tstart_q <= 1'b0;
			sstart_q <= 1'b0;
			acc_q <= 1'b0;
			tick_q <= 1'b0;
			fer_q <= 1'b0;
		end
		else
		begin
			per_q <= per_d;
			sup_q <= sup_d;
			trig_q <= trig_d;
			lock_q <= lock_d;
			en_q <= en_d;
			rflag_q <= rflag_d;
			st_q <= st_d;
			div_q <= div_d;
			cnt_q <= cnt_d;
			tstart_q <= tstart_d;
			sstart_q <= sstart_d;
			acc_q <= acc_d;
			tick_q <= tick_d;
			fer_q <= fer_d;
		end
	end

	assign temp_start = tstart_q;
	assign supply_start = sstart_q;
	assign adc_enable = en_q[`AFE_EN_ADC_BIT]; // R08
	assign ce_enable = en_q[`AFE_EN_CE_BIT]; // R09
	assign sample_tick = tick_q;
	assign accum_done = acc_q;
	assign fe_reset = fer_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_period_cont;
		st_q == AFE_ST_IDLE && per_q == `AFE_PER_CONT && !rst_wr |=> temp_start;
	endproperty
	a_period_cont: assert property (p_period_cont) else $error("continuous mode did not start"); // R01
	property p_supply;
		st_q == AFE_ST_TEMP && sensor_done && sup_q && !rst_wr |=> supply_start && st_q == AFE_ST_SUPPLY;
	endproperty
	a_supply: assert property (p_supply) else $error("supply sample missing"); // R02
	property p_trig_start;
		wr_trig && st_q == AFE_ST_IDLE && !trig_q && !auto_req |-> ##1 trig_q ##1 temp_start;
	endproperty
	a_trig_start: assert property (p_trig_start) else $error("trigger did not start conversion"); // R03
	property p_trig_clear;
		st_q == AFE_ST_SUPPLY && sensor_done && !wr_trig |=> !trig_q && st_q == AFE_ST_IDLE;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared at finish"); // R04
	property p_lock_set;
		wr_stb && addr == `AFE_OFS_LOCK && wdata == `AFE_LOCK_VALUE |=> lock_q;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock word did not lock"); // R05
	property p_lock_block;
		lock_q && addr != `AFE_OFS_LOCK && (wr_stb || rd_stb) |=>
			$stable(per_q) && $stable(en_q) && $stable(sup_q) && rdata == 32'h0000_0000;
	endproperty
	a_lock_block: assert property (p_lock_block) else $error("locked access took effect"); // R06
	property p_unlock;
		wr_stb && addr == `AFE_OFS_LOCK && wdata == `AFE_UNLOCK_VALUE |=> !lock_q;
	endproperty
	a_unlock: assert property (p_unlock) else $error("zero write did not unlock"); // R07
	property p_tick_needs_adc;
		sample_tick |-> $past(adc_enable) && $past(div_q) == 32'(SAMPLE_CYCLES - 1);
	endproperty
	a_tick_needs_adc: assert property (p_tick_needs_adc) else $error("sample tick off period"); // R08 R11
	property p_accum;
		accum_done |-> $past(ce_enable) && $past(cnt_q) == 12'(SAMPLES_PER_ACC - 1) && cnt_q == 12'h000;
	endproperty
	a_accum: assert property (p_accum) else $error("accumulation length wrong"); // R09 R10
	property p_reset_word;
		rst_wr |=> fe_reset && rflag_q && en_q == 2'h0 && !lock_q ##1 !fe_reset;
	endproperty
	a_reset_word: assert property (p_reset_word) else $error("reset word mishandled"); // R12
	property p_reserved;
		rd_stb && acc_ok && addr == `AFE_OFS_CFG |-> rdata[31:5] == 27'h000_0000 && rdata[1:0] == 2'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // R13

	c_trig_supply: cover property (wr_trig ##[1:1000] supply_start);
	c_locked_write: cover property (lock_q && wr_stb && addr == `AFE_OFS_EN);
	c_accum: cover property (accum_done);
	c_reset: cover property (rst_wr);
endmodule : afe_ctrl_regs
`default_nettype wire

// ---- afe_ctrl_regs_bench.sv ----
// Self-checking bench of the control bank: host model at the serial port,
// a simple sensor answering each start. Short timing parameters.
`timescale 1ns/10ps
`default_nettype none
`include "afe_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module afe_ctrl_regs_bench;
	localparam int SC = 4;
	localparam int SPA = 3;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic sensor_done = 1'b0;
	logic cs_n, sclk, mosi, miso, miso_oe, rd_valid, ok_b;
	logic temp_start, supply_start, adc_enable, ce_enable, sample_tick, accum_done, fe_reset;
	logic [31:0] rd_data, v, e;
	logic [31:0] q[$];
	int n_fail = 0;
	int n_compared = 0;
	int n_temp = 0;
	int n_sup = 0;
	int n_rst = 0;
	int n_acc = 0;
	int sens_delay = 600;
	int sens_cnt = 0;
	int g, code;
	always #4 clk = ~clk;
	afe_host_model i_host (.clk(clk), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
		.spi_miso(miso), .spi_miso_oe(miso_oe), .rd_valid(rd_valid), .rd_data(rd_data));
	afe_ctrl_regs #(.SAMPLE_CYCLES(SC), .SAMPLES_PER_ACC(SPA)) i_dut (.clk(clk), .rstn(rstn),
		.spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
		.spi_miso_oe(miso_oe), .sensor_done(sensor_done), .temp_start(temp_start),
		.supply_start(supply_start), .adc_enable(adc_enable), .ce_enable(ce_enable),
		.sample_tick(sample_tick), .accum_done(accum_done), .fe_reset(fe_reset));
	always @(posedge clk)
	begin
		sensor_done <= #1 1'b0;
		if (temp_start === 1'b1 || supply_start === 1'b1)
			sens_cnt <= sens_delay;
		else if (sens_cnt != 0)
		begin
			sens_cnt <= sens_cnt - 1;
			if (sens_cnt == 1)
				sensor_done <= #1 1'b1;
		end
		n_temp += int'(temp_start === 1'b1);
		n_sup += int'(supply_start === 1'b1);
		n_rst += int'(fe_reset === 1'b1);
		n_acc += int'(accum_done === 1'b1);
	end
	always @(posedge clk)
		if (rd_valid === 1'b1)
		begin
			e = q.pop_front();
			`CHK(rd_data, e)
		end
	task final_report();
		if (q.size() != 0)
			n_fail++;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	task wr(input logic [11:0] a, input logic [31:0] d);
		i_host.frame({4'h8, a}, d, 48);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] x);
		q.push_back(x);
		i_host.frame({4'h0, a}, 32'h0, 48);
	endtask : rd
	task gap(input logic sel, input int x);
		int k;
		for (k = 0; k < 99 && (sel ? accum_done : sample_tick) !== 1'b1; k++)
			@(posedge clk) #1;
		if (k == 99)
		begin
			n_fail++;
			$display("unexpected at %0t: tick missing", $time);
			final_report();
		end
		g = 0;
		do
		begin
			@(posedge clk) #1;
			g++;
		end
		while ((sel ? accum_done : sample_tick) !== 1'b1 && g < 99);
		`CHK(g, x)
	endtask : gap
	initial
	begin
		void'($urandom(32'hAF60));
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		for (code = 0; code < 4; code++)
			rd(`AFE_OFS_CFG + 12'(code), 32'h0);
		rd(`AFE_OFS_STATUS, 32'h0);
		$display("test reset values done");
		// Period bits kept zero so no conversion runs yet
		v = $urandom & 32'hFFFF_FFF3;
		wr(`AFE_OFS_CFG, v);
		rd(`AFE_OFS_CFG, v & 32'h0000_001C);
		wr(12'h300, $urandom);
		rd(12'h300, 32'h0);
		$display("test config and unmapped done");
		wr(`AFE_OFS_CFG, 32'h0000_0010);
		n_temp = 0;
		n_sup = 0;
		wr(`AFE_OFS_TRIG, 32'h0000_0001);
		`CHK(n_temp, 0)
		wr(`AFE_OFS_TRIG, `AFE_TRIG_VALUE);
		`CHK(n_temp, 1)
		rd(`AFE_OFS_TRIG, `AFE_TRIG_VALUE);
		repeat (1300) @(posedge clk);
		`CHK(n_sup, 1)
		rd(`AFE_OFS_TRIG, 32'h0);
		$display("test trigger done");
		sens_delay = 3;
		wr(`AFE_OFS_EN, 32'h0000_0003);
		`CHK({ce_enable, adc_enable}, 2'b11)
		rd(`AFE_OFS_EN, 32'h0000_0003);
		gap(1'b0, SC);
		gap(1'b1, SC * SPA);
		for (code = 0; code < 4; code++)
		begin
			wr(`AFE_OFS_CFG, 32'(code << 2));
			n_temp = 0;
			n_acc = 0;
			repeat (200) @(posedge clk);
			ok_b = (code == 2) ? (n_temp > n_acc) : (code == 1) ?
				(n_temp > 0 && n_temp <= n_acc + 1) : (n_temp == 0);
			`CHK(ok_b, 1'b1)
		end
		wr(`AFE_OFS_CFG, 32'h0);
		$display("test enables and period done");
		wr(`AFE_OFS_LOCK, `AFE_LOCK_VALUE);
		rd(`AFE_OFS_LOCK, `AFE_LOCK_VALUE);
		rd(`AFE_OFS_EN, 32'h0);
		wr(`AFE_OFS_EN, 32'h0);
		`CHK(adc_enable, 1'b1)
		wr(`AFE_OFS_LOCK, `AFE_UNLOCK_VALUE);
		rd(`AFE_OFS_EN, 32'h0000_0003);
		// Frame cut short must leave the enables alone
		i_host.frame({4'h8, `AFE_OFS_EN}, 32'h0, 30);
		`CHK(adc_enable, 1'b1)
		$display("test lock and abort done");
		wr(`AFE_OFS_RESET, `AFE_TRIG_VALUE);
		`CHK(n_rst, 0)
		wr(`AFE_OFS_RESET, `AFE_RESET_VALUE);
		`CHK(n_rst, 1)
		`CHK(adc_enable, 1'b0)
		rd(`AFE_OFS_STATUS, 32'h0100_0100);
		rd(`AFE_OFS_EN, 32'h0);
		$display("test reset word done");
		final_report();
	end
endmodule : afe_ctrl_regs_bench
`default_nettype wire

// ---- afe_host_model.sv ----
// Host side serial master model: 48-bit frames, mode 0, MSB first.
// Assumes the bank samples its pins with the same clk.
`timescale 1ns/10ps
`default_nettype none
module afe_host_model
(
	input wire logic clk,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe,
	output logic rd_valid,
	output logic [31:0] rd_data
);
	initial
	begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
		rd_valid = 1'b0;
		rd_data = 32'h0;
	end
	// Half period of 4 clk, twice the least the slave can follow
	task frame(input logic [15:0] cmd, input logic [31:0] dat, input int nbits);
		logic [47:0] sh;
		int i;
		sh = {cmd, dat};
		@(posedge clk) #1 spi_cs_n = 1'b0;
		for (i = 0; i < nbits; i++)
		begin
			spi_mosi = sh[47 - i];
			repeat (4) @(posedge clk);
			#1 spi_sclk = 1'b1;
			if (i >= 16)
				rd_data = {rd_data[30:0], spi_miso_oe ? spi_miso : ~rd_data[0]};
			repeat (4) @(posedge clk);
			#1 spi_sclk = 1'b0;
		end
		repeat (4) @(posedge clk);
		#1 spi_cs_n = 1'b1;
		// Released line shows the inverse, not the last bit
		spi_mosi = ~spi_mosi;
		if (!cmd[15] && nbits == 48)
		begin
			rd_valid = 1'b1;
			@(posedge clk) #1 rd_valid = 1'b0;
		end
		repeat (4) @(posedge clk);
		// Return off the edge so callers never race the bank's registers
		#1;
	endtask : frame
endmodule : afe_host_model
`default_nettype wire

// ---- afe_pkg.sv ----
// Types shared by the front end control bank.
// Assumes afe_regs.svh for the numeric layout.
package afe_pkg;
	typedef enum logic [1:0]
	{
		AFE_ST_IDLE = 2'b00,
		AFE_ST_TEMP = 2'b01,
		AFE_ST_SUPPLY = 2'b11
	} afe_meas_state_e;
endpackage : afe_pkg

// ---- afe_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the
// front end control bank. Definitions only; included by the modules.
// Notes on behaviour
// R01: Period field 01 per accumulation, 10 continuous
// R02: Supply bit adds supply sample each measurement
// R03: Trigger write starts one temperature conversion
// R04: Finished conversion clears trigger bit thirty-one
// R05: Magic lock word write locks serial port
// R06: Locked port ignores all but lock word
// R07: Writing zero to lock word unlocks port
// R08: Enable bit zero powers converter and reference
// R09: Enable bit one runs compute engine
// R10: Accumulation interval spans 2520 converter samples
// R11: Sample rate is two^15 over thirteen
// R12: Reset word resets front end, sets flag
// R13: Reserved bits read zero, writes ignored
`ifndef AFE_REGS_SVH
`define AFE_REGS_SVH

`define AFE_OFS_STATUS 12'h311
`define AFE_OFS_RESET 12'h322
`define AFE_OFS_CFG 12'h323
`define AFE_OFS_TRIG 12'h324
`define AFE_OFS_LOCK 12'h325
`define AFE_OFS_EN 12'h326

`define AFE_CFG_PER_LSB 2
`define AFE_CFG_PER_MSB 3
`define AFE_CFG_SUP_BIT 4
`define AFE_TRIG_BIT 31
`define AFE_EN_ADC_BIT 0
`define AFE_EN_CE_BIT 1
`define AFE_STAT_RST_BIT 8
`define AFE_STAT_RST_COPY_BIT 24

`define AFE_PER_ACCUM 2'h1
`define AFE_PER_CONT 2'h2

`define AFE_TRIG_VALUE 32'h8000_0000
`define AFE_LOCK_VALUE 32'h8000_0000
`define AFE_UNLOCK_VALUE 32'h0000_0000
`define AFE_RESET_VALUE 32'h8100_0000
`define AFE_REG_RESET 32'h0000_0000

`define AFE_CLK_HZ 125000000
`define AFE_FS_NUMER 32768
`define AFE_FS_DENOM 13
`define AFE_SAMPLE_CYCLES ((`AFE_CLK_HZ * `AFE_FS_DENOM) / `AFE_FS_NUMER)
`define AFE_SAMPLES_PER_ACC 2520

`define AFE_SPI_CMD_LAST 6'h0F
`define AFE_SPI_FRAME_LAST 6'h2F
`define AFE_SPI_FRAME_BITS 6'h30

`endif

// ---- afe_spi_slave.sv ----
// Serial slave framing: 16-bit command (write flag in bit 15, offset in 11:0)
// then 32 data bits, mode 0, MSB first. Pins are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "afe_regs.svh"
module afe_spi_slave
	import afe_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	output logic rd_stb,
	output logic wr_stb,
	output logic [11:0] addr,
	output logic [31:0] wdata,
	input wire logic [31:0] rdata
);
	logic sclk_q, sclk_d, wr_flag_q, wr_flag_d, rd_q, rd_d, wr_q, wr_d, miso_q, miso_d;
	logic [5:0] cnt_q, cnt_d;
	logic [30:0] sh_q, sh_d;
	logic [31:0] out_q, out_d, wdata_q, wdata_d;
	logic [11:0] addr_q, addr_d;
	logic rise, fall;

	assign rise = ~spi_cs_n & spi_sclk & ~sclk_q;
	assign fall = ~spi_cs_n & ~spi_sclk & sclk_q;

	always_comb
	begin
		sclk_d = spi_sclk;
		cnt_d = cnt_q;
		sh_d = sh_q;
		wr_flag_d = wr_flag_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		out_d = out_q;
		miso_d = miso_q;
		rd_d = 1'b0;
		wr_d = 1'b0;
		if (spi_cs_n)
		begin
			cnt_d = 6'h00;
			wr_flag_d = 1'b0;
		end
		else if (rise && cnt_q != `AFE_SPI_FRAME_BITS)
		begin
			sh_d = {sh_q[29:0], spi_mosi};
			cnt_d = cnt_q + 6'h01;
			if (cnt_q == `AFE_SPI_CMD_LAST)
			begin
				addr_d = {sh_q[10:0], spi_mosi};
				wr_flag_d = sh_q[14];
				rd_d = ~sh_q[14];
			end
			if (cnt_q == `AFE_SPI_FRAME_LAST && wr_flag_q)
			begin
				wdata_d = {sh_q, spi_mosi};
				wr_d = 1'b1;
			end
		end
		// Read data is captured in the strobe cycle, long before sclk falls
		if (rd_q)
			out_d = rdata;
		else if (fall && cnt_q > `AFE_SPI_CMD_LAST)
		begin
			miso_d = out_q[31];
			out_d = {out_q[30:0], 1'b0};
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclk_q <= 1'b0;
			cnt_q <= 6'h00;
			sh_q <= 31'h0000_0000;
			wr_flag_q <= 1'b0;
			addr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			out_q <= 32'h0000_0000;
			miso_q <= 1'b0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end
		else
		begin
			sclk_q <= sclk_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			wr_flag_q <= wr_flag_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			out_q <= out_d;
			miso_q <= miso_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
		end
	end

	assign rd_stb = rd_q;
	assign wr_stb = wr_q;
	assign addr = addr_q;
	assign wdata = wdata_q;
	assign spi_miso = miso_q;
	assign spi_miso_oe = ~spi_cs_n & ~wr_flag_q & (cnt_q > `AFE_SPI_CMD_LAST);
endmodule : afe_spi_slave
`default_nettype wire
